/* File: rtl/aife_mem.sv */
// small character memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module aife_mem (
  input wire logic i_clk, // clock
  input wire logic i_ce, // clock enable
  input wire logic i_we, // write enable
  input wire logic [aife_pkg::LEN_W-1:0] i_waddr, // write address
  input wire logic [aife_pkg::CHAR_W-1:0] i_wdata, // write data
  input wire logic [aife_pkg::LEN_W-1:0] i_raddr, // read address
  output logic [aife_pkg::CHAR_W-1:0] o_rdata // registered read data
);
  logic [aife_pkg::CHAR_W-1:0] mem [aife_pkg::BUF_DEPTH];

  always_ff @(posedge i_clk) begin
    if (i_ce && i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      o_rdata <= mem[i_raddr];
    end
  end
endmodule
`default_nettype wire

/* File: rtl/aife_pkg.sv */
// constants and types for the ascii input field extractor
package aife_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned GAP_TIME_MS = 1000;
  localparam int unsigned GAP_CYCLES = CLK_HZ / 1000 * GAP_TIME_MS;
  localparam int unsigned CHAR_W = 8;
  localparam int unsigned LEN_W = 6;
  localparam int unsigned BUF_DEPTH = 64;
  localparam int unsigned DEST_W = 3;
  localparam logic [CHAR_W-1:0] CTRL_MAX = 8'h1F;
  localparam logic [CHAR_W-1:0] DEL_CODE = 8'h7F;
  localparam logic [LEN_W-1:0] CNT_RESET = 6'h00;
  localparam logic [31:0] GAP_RESET = 32'h00000000;
  // destination selector codes
  localparam logic [DEST_W-1:0] DEST_IDENT_ONE = 3'h0;
  localparam logic [DEST_W-1:0] DEST_KEYPAD = 3'h1;
  localparam logic [DEST_W-1:0] DEST_TARE_VALUE = 3'h2;
  localparam logic [DEST_W-1:0] DEST_TARE_KEY = 3'h3;
  localparam logic [DEST_W-1:0] DEST_TARGET_KEY = 3'h4;
  localparam logic [DEST_W-1:0] DEST_FILL_KEY = 3'h5;
  localparam logic [DEST_W-1:0] DEST_ACT_TARGET = 3'h6;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RECV = 3'b010,
    ST_SEND = 3'b100
  } aife_state_e;
endpackage

/* File: rtl/aife_top.sv */
// ascii input field extractor: template strip, terminate, deliver
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - The first preamble-count characters of each string are thrown away.
// - Following characters are captured up to the data length, no more.
// - The last postamble-count captured characters before the end drop out.
// - A received character equal to the set control terminator ends it.
// - With no terminator selected only the gap timeout ends a string.
// - A gap of more than one second without a character ends a string.
// - At the end the collected field goes to the one selected destination.
// - Seven destinations exist, from identification text one to target.
// - Tare or target record key destinations start a table look-up.
module aife_top #(
  parameter int unsigned GAP_CYCLES = aife_pkg::GAP_CYCLES // gap count
) (
  input wire logic I_CLK, // system clock
  input wire logic I_ARST_N, // async reset, active low
  input wire logic I_CE, // clock enable
  input wire logic I_RX_VALID, // one-cycle pulse: character received
  input wire logic [7:0] I_RX_CHAR, // received character
  input wire logic [5:0] I_PRE_LEN, // preamble length
  input wire logic [5:0] I_DATA_LEN, // maximum data length
  input wire logic [5:0] I_POST_LEN, // postamble length
  input wire logic I_TERM_EN, // terminator selected (0 = none)
  input wire logic [7:0] I_TERM_CHAR, // terminator control code
  input wire logic [2:0] I_DEST_SEL, // destination selector
  output logic O_FIELD_VALID, // field character valid
  output logic [7:0] O_FIELD_CHAR, // field character
  output logic O_FIELD_LAST, // last character of field
  output logic O_FIELD_DONE, // pulse: field delivered
  output logic [5:0] O_FIELD_LEN, // delivered field length
  output logic [6:0] O_DEST_STB, // one-hot destination strobe
  output logic O_TARE_LOOKUP, // pulse: start tare table look-up
  output logic O_TARGET_LOOKUP, // pulse: start target table look-up
  output logic O_BUSY // string being received or sent
);
  aife_pkg::aife_state_e state_q;
  logic [5:0] seen_q, cap_q, send_len_q, rd_q;
  logic [31:0] gap_q;
  logic pend_q;
  logic [2:0] dest_q;
  logic [7:0] rdata;
  logic term_hit, gap_hit, cap_en, end_str;
  logic [5:0] fin_len;
  logic [5:0] rd_d;

  // ------------------------------------------------------------
  // string end detection
  // ------------------------------------------------------------
  assign term_hit = I_TERM_EN && I_RX_VALID
    && ((I_TERM_CHAR <= aife_pkg::CTRL_MAX)
    || (I_TERM_CHAR == aife_pkg::DEL_CODE))
    && (I_RX_CHAR == I_TERM_CHAR);
  assign gap_hit = (state_q == aife_pkg::ST_RECV) && !I_RX_VALID
    && (gap_q >= GAP_CYCLES);
  assign end_str = (state_q == aife_pkg::ST_RECV) && (term_hit || gap_hit);
  assign cap_en = I_RX_VALID && !term_hit && (seen_q >= I_PRE_LEN)
    && (cap_q < I_DATA_LEN) && (state_q != aife_pkg::ST_SEND);
  assign fin_len = (cap_q > I_POST_LEN) ? 6'(cap_q - I_POST_LEN)
    : aife_pkg::CNT_RESET;

  // ------------------------------------------------------------
  // state machine
  // ------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      state_q <= aife_pkg::ST_IDLE;
    end else if (I_CE) begin
      unique case (state_q)
        aife_pkg::ST_IDLE: begin
          // terminator while idle is dropped, no empty string starts
          if (I_RX_VALID && !term_hit) begin
            state_q <= aife_pkg::ST_RECV;
          end
        end
        aife_pkg::ST_RECV: begin
          if (end_str) begin
            state_q <= aife_pkg::ST_SEND;
          end
        end
        aife_pkg::ST_SEND: begin
          if (!pend_q) begin
            state_q <= aife_pkg::ST_IDLE;
          end
        end
        default: state_q <= aife_pkg::ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // counters and gap timer
  // ------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      seen_q <= aife_pkg::CNT_RESET;
      cap_q <= aife_pkg::CNT_RESET;
    end else if (I_CE) begin
      if (state_q == aife_pkg::ST_SEND) begin
        seen_q <= aife_pkg::CNT_RESET;
        cap_q <= aife_pkg::CNT_RESET;
      end else if (I_RX_VALID && !term_hit) begin
        if (seen_q < I_PRE_LEN) begin
          seen_q <= 6'(seen_q + 6'h01);
        end
        if (cap_en) begin
          cap_q <= 6'(cap_q + 6'h01);
        end
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      gap_q <= aife_pkg::GAP_RESET;
    end else if (I_CE) begin
      if (I_RX_VALID || state_q != aife_pkg::ST_RECV) begin
        gap_q <= aife_pkg::GAP_RESET;
      end else if (gap_q < GAP_CYCLES) begin
        // saturates so a silent line never wraps
        gap_q <= gap_q + 32'h00000001;
      end
    end
  end

  // ------------------------------------------------------------
  // capture buffer
  // ------------------------------------------------------------
  assign rd_d = (state_q == aife_pkg::ST_SEND && pend_q)
    ? 6'(rd_q + 6'h01) : aife_pkg::CNT_RESET;

  aife_mem u_mem (
    .i_clk(I_CLK),
    .i_ce(I_CE),
    .i_we(cap_en),
    .i_waddr(cap_q),
    .i_wdata(I_RX_CHAR),
    .i_raddr(rd_q),
    .o_rdata(rdata)
  );

  // ------------------------------------------------------------
  // delivery
  // ------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      pend_q <= 1'b0;
      rd_q <= aife_pkg::CNT_RESET;
      send_len_q <= aife_pkg::CNT_RESET;
      dest_q <= aife_pkg::DEST_IDENT_ONE;
    end else if (I_CE) begin
      if (end_str) begin
        pend_q <= 1'b1;
        rd_q <= aife_pkg::CNT_RESET;
        send_len_q <= fin_len;
        dest_q <= I_DEST_SEL;
      end else if (state_q == aife_pkg::ST_SEND) begin
        // chars seen during send are refused, not queued
        rd_q <= rd_d;
        if (rd_q >= send_len_q) begin
          pend_q <= 1'b0;
        end
      end
    end
  end

  // memory data lags address by a cycle; valid for rd_q-1 < len
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_FIELD_VALID <= 1'b0;
      O_FIELD_CHAR <= 8'h00;
      O_FIELD_LAST <= 1'b0;
    end else if (I_CE) begin
      O_FIELD_VALID <= 1'b0;
      O_FIELD_LAST <= 1'b0;
      if (state_q == aife_pkg::ST_SEND && pend_q && rd_q != 6'h00
          && rd_q <= send_len_q) begin
        O_FIELD_VALID <= 1'b1;
        O_FIELD_CHAR <= rdata;
        O_FIELD_LAST <= (rd_q == send_len_q);
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_FIELD_DONE <= 1'b0;
      O_FIELD_LEN <= aife_pkg::CNT_RESET;
      O_DEST_STB <= 7'h00;
      O_TARE_LOOKUP <= 1'b0;
      O_TARGET_LOOKUP <= 1'b0;
    end else if (I_CE) begin
      O_FIELD_DONE <= 1'b0;
      O_DEST_STB <= 7'h00;
      O_TARE_LOOKUP <= 1'b0;
      O_TARGET_LOOKUP <= 1'b0;
      if (state_q == aife_pkg::ST_SEND && pend_q
          && rd_q >= send_len_q) begin
        O_FIELD_DONE <= 1'b1;
        O_FIELD_LEN <= send_len_q;
        if (dest_q <= aife_pkg::DEST_ACT_TARGET) begin
          O_DEST_STB <= 7'(7'h01 << dest_q);
        end
        O_TARE_LOOKUP <= (dest_q == aife_pkg::DEST_TARE_KEY);
        O_TARGET_LOOKUP <= (dest_q == aife_pkg::DEST_TARGET_KEY);
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_BUSY <= 1'b0;
    end else if (I_CE) begin
      O_BUSY <= (state_q != aife_pkg::ST_IDLE);
    end
  end
endmodule
`default_nettype wire

/* File: sim/aife_monitor.sv */
// port assertions for the ascii input field extractor
`timescale 1ns/1ps
`default_nettype none
module aife_monitor #(
  parameter int unsigned GAP_CYCLES = 50 // gap count
) (
  input wire logic I_CLK, // clock
  input wire logic I_ARST_N, // reset, low
  input wire logic I_RX_VALID, // char pulse
  input wire logic [7:0] I_RX_CHAR, // char
  input wire logic I_TERM_EN, // terminator on
  input wire logic [7:0] I_TERM_CHAR, // terminator
  input wire logic O_FIELD_VALID, // field char
  input wire logic O_FIELD_LAST, // last char
  input wire logic O_FIELD_DONE, // done pulse
  input wire logic [5:0] O_FIELD_LEN, // length
  input wire logic [6:0] O_DEST_STB, // dest strobe
  input wire logic O_TARE_LOOKUP, // tare look-up
  input wire logic O_TARGET_LOOKUP, // target look-up
  input wire logic O_BUSY // busy
);
  int unsigned gap_q;
  logic [5:0] cnt_q;
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_ARST_N);
  // idle cycles while busy, and field chars sent so far
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) gap_q <= 0;
    else if (I_RX_VALID || !O_BUSY) gap_q <= 0;
    else gap_q <= gap_q + 1;
  end
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) cnt_q <= 6'h00;
    else if (O_FIELD_DONE) cnt_q <= 6'h00;
    else if (O_FIELD_VALID) cnt_q <= cnt_q + 6'h01;
  end
  // done pulses together with the last char, then the field goes quiet
  sequence s_last;
    O_FIELD_LAST && O_FIELD_DONE ##1 !O_FIELD_VALID;
  endsequence
  sequence s_term;
    I_RX_VALID && I_TERM_EN && I_RX_CHAR == I_TERM_CHAR && O_BUSY &&
    (I_TERM_CHAR <= 8'h1F || I_TERM_CHAR == 8'h7F);
  endsequence
  last_then_done_a: assert property (
    O_FIELD_LAST |-> O_FIELD_VALID ##0 s_last) else $error("no done");
  done_pulse_a: assert property (
    O_FIELD_DONE |=> !O_FIELD_DONE) else $error("done too long");
  strobe_onehot_a: assert property (
    O_DEST_STB != 7'h00 |-> O_FIELD_DONE && $onehot(O_DEST_STB))
    else $error("bad strobe");
  tare_lookup_a: assert property (
    O_TARE_LOOKUP == O_DEST_STB[3]) else $error("tare look-up");
  target_lookup_a: assert property (
    O_TARGET_LOOKUP == O_DEST_STB[4]) else $error("target look-up");
  field_len_a: assert property (
    O_FIELD_DONE |-> O_FIELD_LEN == 6'(cnt_q + {5'h00, O_FIELD_VALID}))
    else $error("bad length");
  gap_bound_a: assert property (
    gap_q < GAP_CYCLES + 70) else $error("gap did not end string");
  term_end_a: assert property (
    s_term and !O_FIELD_DONE && !$past(O_FIELD_DONE) |-> ##[1:80]
    O_FIELD_DONE) else $error("terminator did not end string");
  valid_busy_a: assert property (
    O_FIELD_VALID |-> O_BUSY) else $error("field while idle");
endmodule
bind aife_top aife_monitor #(.GAP_CYCLES(GAP_CYCLES)) u_mon (
  .I_CLK(I_CLK), .I_ARST_N(I_ARST_N), .I_RX_VALID(I_RX_VALID),
  .I_RX_CHAR(I_RX_CHAR), .I_TERM_EN(I_TERM_EN), .I_TERM_CHAR(I_TERM_CHAR),
  .O_FIELD_VALID(O_FIELD_VALID), .O_FIELD_LAST(O_FIELD_LAST),
  .O_FIELD_DONE(O_FIELD_DONE), .O_FIELD_LEN(O_FIELD_LEN),
  .O_DEST_STB(O_DEST_STB), .O_TARE_LOOKUP(O_TARE_LOOKUP),
  .O_TARGET_LOOKUP(O_TARGET_LOOKUP), .O_BUSY(O_BUSY));
`default_nettype wire

/* File: sim/aife_scanner.sv */
// character source standing in for the scanner
`timescale 1ns/1ps
`default_nettype none
module aife_scanner (
  input wire logic i_clk, // clock
  output logic o_valid, // char pulse
  output logic [7:0] o_char // char
);
  initial begin
    o_valid = 1'b0;
    o_char = 8'h00;
  end
  // one-cycle pulse, data inverted afterwards so it is never stale
  task automatic put(input logic [7:0] c, input int gap);
    @(posedge i_clk);
    o_valid <= 1'b1;
    o_char <= c;
    @(posedge i_clk);
    o_valid <= 1'b0;
    o_char <= ~c;
    repeat (gap) @(posedge i_clk);
  endtask
endmodule
`default_nettype wire

/* File: sim/aife_top_tb.sv */
// self-checking bench for the ascii input field extractor
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module aife_top_tb;
  localparam int GAP = 50;
  logic I_CLK = 1'b0;
  logic I_ARST_N = 1'b0;
  logic I_TERM_EN = 1'b1;
  logic [5:0] I_PRE_LEN = 6'h00, I_DATA_LEN = 6'h00, I_POST_LEN = 6'h00;
  logic [7:0] I_TERM_CHAR = 8'h0D;
  logic [2:0] I_DEST_SEL = 3'h0;
  wire logic I_RX_VALID;
  wire logic [7:0] I_RX_CHAR;
  logic O_FIELD_VALID, O_FIELD_LAST, O_FIELD_DONE, O_BUSY;
  logic O_TARE_LOOKUP, O_TARGET_LOOKUP, d_tare, d_tgt;
  logic [7:0] O_FIELD_CHAR;
  logic [5:0] O_FIELD_LEN, d_len;
  logic [6:0] O_DEST_STB, d_stb;
  logic [7:0] s[$], got[$];
  logic done_seen = 1'b0;
  int fails = 0, num_checks = 0, seed = 82967, n, p, d, q, m, w;
  initial forever #20 I_CLK = ~I_CLK;
  aife_top #(.GAP_CYCLES(GAP)) uut (.I_CLK(I_CLK), .I_ARST_N(I_ARST_N),
    .I_CE(1'b1), .I_RX_VALID(I_RX_VALID), .I_RX_CHAR(I_RX_CHAR),
    .I_PRE_LEN(I_PRE_LEN), .I_DATA_LEN(I_DATA_LEN), .I_POST_LEN(I_POST_LEN),
    .I_TERM_EN(I_TERM_EN), .I_TERM_CHAR(I_TERM_CHAR),
    .I_DEST_SEL(I_DEST_SEL), .O_FIELD_VALID(O_FIELD_VALID),
    .O_FIELD_CHAR(O_FIELD_CHAR), .O_FIELD_LAST(O_FIELD_LAST),
    .O_FIELD_DONE(O_FIELD_DONE), .O_FIELD_LEN(O_FIELD_LEN),
    .O_DEST_STB(O_DEST_STB), .O_TARE_LOOKUP(O_TARE_LOOKUP),
    .O_TARGET_LOOKUP(O_TARGET_LOOKUP), .O_BUSY(O_BUSY));
  aife_scanner scn (.i_clk(I_CLK), .o_valid(I_RX_VALID), .o_char(I_RX_CHAR));
  function automatic int exp_len(int n, int p, int d, int q);
    int c;
    c = n > p ? n - p : 0;
    if (c > d) c = d;
    return c > q ? c - q : 0;
  endfunction
  task automatic print_verdict;
    if (fails == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge I_CLK) begin
    if (O_FIELD_VALID) got.push_back(O_FIELD_CHAR);
    if (O_FIELD_DONE) begin
      done_seen = 1'b1;
      d_len = O_FIELD_LEN;
      d_stb = O_DEST_STB;
      {d_tare, d_tgt} = {O_TARE_LOOKUP, O_TARGET_LOOKUP};
    end
  end
  initial begin
    repeat (40 * (GAP + 300)) @(posedge I_CLK);
    fails++;
    print_verdict;
  end
  // ---------------------------------------------------------------
  // template strings: two fixed walks, then random ones
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(posedge I_CLK);
    I_ARST_N <= 1'b1;
    for (int k = 0; k < 24; k++) begin
      s = {8'h02, 8'h50, 8'h30, 8'h30, 8'h31, 8'h2E, 8'h35, 8'h20, 8'h6B,
           8'h67};
      p = k < 2 ? 2 : $random(seed) & 3;
      d = k == 0 ? 5 : k == 1 ? 8 : 1 + ($random(seed) & 7);
      q = k == 1 ? 3 : k == 0 ? 0 : $random(seed) & 3;
      m = k == 2 ? 127 : k < 2 ? 13 : $random(seed) & 31;
      if (k > 1) begin
        s = {};
        repeat ($random(seed) & 15) s.push_back(8'(32 + ($random(seed) & 63)));
        if (k[0] && s.size() > p) s[p] = 8'(m);
      end
      n = s.size();
      I_PRE_LEN <= 6'(p);
      I_DATA_LEN <= 6'(d);
      I_POST_LEN <= 6'(q);
      I_TERM_EN <= !k[0];
      I_TERM_CHAR <= 8'(m);
      I_DEST_SEL <= 3'(k);
      got = {};
      done_seen = 1'b0;
      @(posedge I_CLK);
      foreach (s[i]) scn.put(s[i], $random(seed) & 3);
      if (!k[0]) scn.put(8'(m), 0);
      for (w = 0; w < GAP + 200 && !done_seen; w++) @(posedge I_CLK);
      m = exp_len(n, p, d, q);
      `CHK(done_seen, n > 0)
      if (n > 0) begin
        `CHK(w > GAP - 5, k[0])
        `CHK(got.size(), m)
        `CHK(d_len, 6'(m))
        `CHK(d_stb, k % 8 < 7 ? 7'h01 << k % 8 : 7'h00)
        `CHK({d_tare, d_tgt}, {k % 8 == 3, k % 8 == 4})
        foreach (got[i]) `CHK(got[i], s[p + i])
      end
      repeat (5) @(posedge I_CLK);
    end
    print_verdict;
  end
endmodule
`default_nettype wire
